// >>> bench/fdio_master_model.sv
/*
 * behavioural fieldbus master: parameter bytes, cyclic output data and
 * the communication-good level.
 * assumes its tasks are called at the falling edge of sys_clk.
 */
`timescale 1ns/1ps

module fdio_master_model (
	input  wire logic  sys_clk,
	output logic       prm_we,
	output logic [7:0] prm_idx,
	output logic [7:0] prm_data,
	output logic       out_valid,
	output logic [15:0] out_data,
	output logic       comm_ok
);
	initial begin
		prm_we = 1'b0;
		prm_idx = 8'h00;
		prm_data = 8'h00;
		out_valid = 1'b0;
		out_data = 16'h0000;
		comm_ok = 1'b0;
	end

	// one parameter byte per strobe, index 0x0b..0x0e
	// strobe rests a cycle so back-to-back calls never abut
	task automatic prm(input logic [7:0] idx, input logic [7:0] d);
		prm_we = 1'b1;
		prm_idx = idx;
		prm_data = d;
		@(negedge sys_clk);
		prm_we = 1'b0;
		prm_idx = ~idx;
		prm_data = ~d;
		@(negedge sys_clk);
	endtask

	// bit i is channel i+1; the caller keeps input channels at zero
	task automatic out(input logic [15:0] d);
		out_valid = 1'b1;
		out_data = d;
		@(negedge sys_clk);
		out_valid = 1'b0;
		// released data is garbage, not the last value
		out_data = ~d;
		@(negedge sys_clk);
	endtask

	task automatic set_comm(input logic b);
		comm_ok = b;
	endtask
endmodule

// >>> bench/fieldbus_dio16_channel_map_tb_top.sv
/*
 * self-checking bench of the i/o port: expected values are queued with
 * a due cycle and compared by a watcher just after each falling edge.
 * assumes fdio_top with sixteen channels and its pipeline latencies.
 */
`timescale 1ns/1ps

module fieldbus_dio16_channel_map_tb_top;
	typedef struct {
		int          due;
		int          kind;
		logic [31:0] v;
	} fdio_note_t;

	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        prm_we, out_valid, comm_ok, uv_in;
	logic [7:0]  prm_idx, prm_data, pin4_in, pin2_in;
	logic [15:0] out_data, short_in, ovl_in, in_data, led_yellow, led_red;
	logic [31:0] status_word;
	logic [7:0]  status_slot, pin4_out, pin2_out;
	logic [15:0] lfsr = 16'h1ca9;
	logic [15:0] d, lo_hi, e;
	fdio_note_t  q[$];
	fdio_note_t  n;
	int          cyc, mismatches, checks;

	always #50 sys_clk = ~sys_clk;

	fdio_master_model u_mst (.sys_clk(sys_clk), .prm_we(prm_we),
		.prm_idx(prm_idx), .prm_data(prm_data), .out_valid(out_valid),
		.out_data(out_data), .comm_ok(comm_ok));

	fdio_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .prm_we(prm_we),
		.prm_idx(prm_idx), .prm_data(prm_data), .out_valid(out_valid),
		.out_data(out_data), .comm_ok(comm_ok), .conn_pin4_in(pin4_in),
		.conn_pin2_in(pin2_in), .ch_short_in(short_in),
		.ch_ovl_in(ovl_in), .uv_in(uv_in), .in_data(in_data),
		.status_word(status_word), .status_slot(status_slot),
		.conn_pin4_out(pin4_out), .conn_pin2_out(pin2_out),
		.led_yellow(led_yellow), .led_red(led_red));

	////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	function automatic logic [31:0] drv_w();
		logic [15:0] w;
		for (int k = 0; k < 8; k++) begin
			w[2*k] = pin4_out[k];
			w[2*k+1] = pin2_out[k];
		end
		return {16'h0000, w};
	endfunction

	task automatic set_pins(input logic [15:0] r);
		for (int k = 0; k < 8; k++) begin
			pin4_in[k] = r[2*k];
			pin2_in[k] = r[2*k+1];
		end
	endtask

	task automatic note(input int kind, input logic [31:0] v, input int lat);
		q.push_back('{cyc + lat, kind, v});
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic idle(input int c);
		repeat (c) @(negedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////
	// watcher: offset from the edge so drivers have pushed their notes
	always @(negedge sys_clk) begin
		#1;
		cyc++;
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			case (n.kind)
				0: chk(drv_w(), n.v);
				1: chk({16'h0000, in_data}, n.v);
				2: chk({16'h0000, led_yellow}, n.v);
				3: chk({16'h0000, led_red}, n.v);
				4: chk(status_word, n.v);
				default: chk({24'h000000, status_slot}, n.v);
			endcase
		end
	end

	// hang guard: far above the longest sequence below
	initial begin
		#2000000;
		mismatches++;
		finish_test();
	end

	initial begin
		{pin4_in, pin2_in, short_in, ovl_in, uv_in} = '0;
		idle(10);
		arst_n = 1'b1;
		note(5, 32'h01, 1);
		note(4, 32'h0, 1);
		u_mst.set_comm(1'b1);
		idle(1);
		// outputs follow cyclic data; the echo shows in the input word
		for (int i = 0; i < 6; i++) begin
			d = rnd();
			u_mst.out(d);
			note(0, {16'h0, d}, 1);
			note(1, {16'h0, d}, 2);
			note(2, {16'h0, d}, 2);
			note(3, 32'h0, 2);
		end
		// pure inputs, outputs of those channels left alone
		u_mst.out(16'h0000);
		d = rnd();
		set_pins(d);
		note(1, {16'h0, d}, 7);
		note(2, {16'h0, d}, 7);
		idle(8);
		set_pins(16'h0000);
		// faults on driven channels: red light and status bits
		u_mst.out(16'h0003);
		short_in = 16'h0001;
		ovl_in = 16'h0002;
		uv_in = 1'b1;
		note(3, 32'h3, 7);
		note(2, 32'h0, 7);
		note(4, 32'h23, 7);
		idle(8);
		{short_in, ovl_in, uv_in} = '0;
		note(4, 32'h0, 7);
		idle(8);
		// substitute behaviour, reserved bits of the mode byte set
		lo_hi = rnd();
		d = rnd();
		u_mst.out(d);
		u_mst.prm(8'h0c, lo_hi[7:0]);
		u_mst.prm(8'h0d, lo_hi[15:8]);
		u_mst.prm(8'h0e, 8'hff);
		// the hold mode lands while the link is still good, so hold keeps the data
		for (int m = 2; m < 6; m++) begin
			u_mst.prm(8'h0b, {6'b101101, m[1:0]});
			u_mst.set_comm(1'b0);
			u_mst.out(~d);
			e = (m == 2) ? d : (m == 3) ? lo_hi : (m == 5) ? 16'hffff : 16'h0;
			note(0, {16'h0, e}, 4);
			idle(5);
		end
		// after restore the drive holds until fresh data arrives
		u_mst.set_comm(1'b1);
		note(0, 32'hffff, 4);
		idle(5);
		d = rnd();
		u_mst.out(d);
		note(0, {16'h0, d}, 2);
		idle(5);
		// notes still queued were never compared
		if (q.size() != 0) begin
			mismatches++;
		end
		finish_test();
	end
endmodule

// >>> src/fdio_chan.sv
/*
 * one i/o channel: pin and fault synchronisers with agreement filter,
 * and the yellow/red channel indicator.
 * assumes pin, short and overload levels arrive asynchronously.
 */
`timescale 1ns/1ps

module fdio_chan (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic pin_in,
	input  wire logic short_in,
	input  wire logic ovl_in,
	input  wire logic drive,
	output logic      pin_f,
	output logic      short_f,
	output logic      ovl_f,
	output logic      led_yellow,
	output logic      led_red
);

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] f;
		logic       led_y;
		logic       led_r;
	} fdio_chan_st_t;

	fdio_chan_st_t st_q;
	fdio_chan_st_t st_d;
	logic          fault;

	////////////////////////////////////////////////////////////////////
	assign fault = st_q.f[1] | st_q.f[2];

	always_comb begin
		st_d    = st_q;
		st_d.s1 = {ovl_in, short_in, pin_in};
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// a level counts only once second and third stages agree
		for (int i = 0; i < 3; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.f[i] = st_q.s2[i];
			end
		end
		// driven channel shows output state, otherwise the input
		if (drive) begin
			st_d.led_y = ~fault;
			st_d.led_r = fault;
		end else begin
			st_d.led_y = st_q.f[0];
			st_d.led_r = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_f      = st_q.f[0];
	assign short_f    = st_q.f[1];
	assign ovl_f      = st_q.f[2];
	assign led_yellow = st_q.led_y;
	assign led_red    = st_q.led_r;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	AST_LED_INPUT: assert property (
		!drive |=> (led_yellow == $past(pin_f)) && !led_red)
		else $error("input channel indicator wrong");

	AST_LED_FAULT: assert property (
		drive && (short_f || ovl_f) |=> led_red && !led_yellow)
		else $error("faulted output not red");

endmodule

// >>> src/fdio_pkg.sv
/*
 * shared constants of the sixteen-channel fieldbus digital i/o port:
 * module parameter indices, substitute modes, status word layout, resets.
 * assumes the fieldbus engine hands over parameter bytes by index.
 */
package fdio_pkg;

	localparam int unsigned FDIO_CH     = 16;
	localparam int unsigned FDIO_BYTE_W = 8;
	localparam int unsigned FDIO_CONN   = FDIO_CH / 2;
	localparam int unsigned FDIO_ST_W   = 32;

	////////////////////////////////////////////////////////////////////
	// module parameter byte indices
	localparam logic [7:0] FDIO_PRM_BEHAV  = 8'h0b;
	localparam logic [7:0] FDIO_PRM_LVL_LO = 8'h0c;
	localparam logic [7:0] FDIO_PRM_LVL_HI = 8'h0d;

	// substitute behaviour code, low two bits of the behaviour byte
	localparam int unsigned FDIO_MODE_W = 2;

	typedef enum logic [1:0] {
		FDIO_SUB_LOW  = 2'b00,
		FDIO_SUB_HIGH = 2'b01,
		FDIO_SUB_HOLD = 2'b10,
		FDIO_SUB_LVL  = 2'b11
	} fdio_sub_t;

	////////////////////////////////////////////////////////////////////
	// status word bit positions
	localparam int unsigned FDIO_ST_SHORT = 0;
	localparam int unsigned FDIO_ST_OVL   = 1;
	localparam int unsigned FDIO_ST_UV    = 5;

	localparam logic [7:0] FDIO_STATUS_SLOT = 8'h01;

	////////////////////////////////////////////////////////////////////
	// reset values
	localparam fdio_sub_t        FDIO_RST_MODE = FDIO_SUB_LOW;
	localparam logic [7:0]       FDIO_RST_LVL  = 8'h00;
	localparam logic [15:0]      FDIO_RST_OUT  = 16'h0000;
	localparam logic [31:0]      FDIO_RST_ST   = 32'h0000_0000;
	localparam logic [2:0]       FDIO_RST_SYNC = 3'h0;

endpackage

// >>> src/fdio_top.sv
/*
 * sixteen-channel digital i/o port of a fieldbus slave: channel map,
 * output substitute behaviour, module parameters, status word.
 * assumes the fieldbus engine on sys_clk delivers parameter bytes,
 * cyclic output data with a strobe, and a communication-good level.
 */
`timescale 1ns/1ps

// What this block does
// - input channel lights yellow while its input is set, dark otherwise
// - output channel: yellow when driven, red on short/overload, else off
// - indicator label digits give process byte then bit in that byte
// - inputs 1-8 in byte 0, 9-16 in byte 1; odd pin 4, even pin 2
// - master writes outputs 1-8 to byte 0, 9-16 to byte 1
// - status module sits in slot 1 with a 32-bit status word
// - status bit 0 short, bit 1 overload, bit 5 undervoltage; rest zero
// - direction follows how the master uses the process data, and the substitute code while communication fails
// - a channel used as output echoes its state into input data
// - parameter byte 11 bits 0-1 select substitute behaviour
// - codes: 00 all low, 01 all high, 10 hold, 11 per-channel values
// - byte 12 bit n is the substitute level of channel n+1
// - byte 13 holds channels 9-16, byte 12 bit 7 holds channel 8
// - on failed communication outputs take the substitute behaviour
module fdio_top #(
	parameter int unsigned CH = fdio_pkg::FDIO_CH
) (
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	input  wire logic          prm_we,
	input  wire logic [7:0]    prm_idx,
	input  wire logic [7:0]    prm_data,
	input  wire logic          out_valid,
	input  wire logic [CH-1:0] out_data,
	input  wire logic          comm_ok,
	input  wire logic [CH/2-1:0] conn_pin4_in,
	input  wire logic [CH/2-1:0] conn_pin2_in,
	input  wire logic [CH-1:0] ch_short_in,
	input  wire logic [CH-1:0] ch_ovl_in,
	input  wire logic          uv_in,
	output logic [CH-1:0]      in_data,
	output logic [31:0]        status_word,
	output logic [7:0]         status_slot,
	output logic [CH/2-1:0]    conn_pin4_out,
	output logic [CH/2-1:0]    conn_pin2_out,
	output logic [CH-1:0]      led_yellow,
	output logic [CH-1:0]      led_red
);

	typedef struct packed {
		fdio_pkg::fdio_sub_t mode;
		logic [7:0]          lvl_lo;
		logic [7:0]          lvl_hi;
		logic [CH-1:0]       drive;
		logic [CH-1:0]       in_proc;
		logic [31:0]         status;
		logic [2:0]          uv_sync;
		logic                uv_f;
	} fdio_top_st_t;

	fdio_top_st_t  st_q;
	fdio_top_st_t  st_d;
	logic [CH-1:0] device_input_channel;
	logic [CH-1:0] pin_f;
	logic [CH-1:0] short_f;
	logic [CH-1:0] ovl_f;
	logic [CH-1:0] sub_lvl;

	////////////////////////////////////////////////////////////////////
	// connector k carries channel 2k+1 on pin 4 and 2k+2 on pin 2
	generate
		for (genvar k = 0; k < CH/2; k++) begin : g_conn
			assign device_input_channel[2*k]   = conn_pin4_in[k];
			assign device_input_channel[2*k+1] = conn_pin2_in[k];
			assign conn_pin4_out[k] = st_q.drive[2*k];
			assign conn_pin2_out[k] = st_q.drive[2*k+1];
		end
	endgenerate

	// channel n sits at index n-1, so index = byte*8 + bit: label "bb"
	generate
		for (genvar c = 0; c < CH; c++) begin : g_ch
			fdio_chan u_chan (
				.sys_clk    (sys_clk),
				.arst_n     (arst_n),
				.pin_in     (device_input_channel[c]),
				.short_in   (ch_short_in[c]),
				.ovl_in     (ch_ovl_in[c]),
				.drive      (st_q.drive[c]),
				.pin_f      (pin_f[c]),
				.short_f    (short_f[c]),
				.ovl_f      (ovl_f[c]),
				.led_yellow (led_yellow[c]),
				.led_red    (led_red[c])
			);
		end
	endgenerate

	assign sub_lvl = {st_q.lvl_hi, st_q.lvl_lo};

	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;

		// parameter bytes; other indices belong to the fieldbus engine
		if (prm_we) begin
			if (prm_idx == fdio_pkg::FDIO_PRM_BEHAV) begin
				// reserved upper bits dropped before the decode
				st_d.mode = fdio_pkg::fdio_sub_t'(
					prm_data[fdio_pkg::FDIO_MODE_W-1:0]);
			end else if (prm_idx == fdio_pkg::FDIO_PRM_LVL_LO) begin
				st_d.lvl_lo = prm_data;
			end else if (prm_idx == fdio_pkg::FDIO_PRM_LVL_HI) begin
				st_d.lvl_hi = prm_data;
			end
		end

		// output path: substitute only while communication is bad
		if (!comm_ok) begin
			case (st_q.mode)
				fdio_pkg::FDIO_SUB_LOW: begin
					st_d.drive = '0;
				end
				fdio_pkg::FDIO_SUB_HIGH: begin
					st_d.drive = '1;
				end
				fdio_pkg::FDIO_SUB_HOLD: begin
					st_d.drive = st_q.drive;
				end
				default: begin
					st_d.drive = sub_lvl;
				end
			endcase
		end else if (out_valid) begin
			// a set data bit is what makes the channel an output
			st_d.drive = out_data;
		end

		// driven bits echo the output; others show the filtered pin.
		// relies on the master not driving a channel it reads as input
		st_d.in_proc = st_q.drive | pin_f;

		st_d.uv_sync = {st_q.uv_sync[1:0], uv_in};
		if (st_q.uv_sync[1] == st_q.uv_sync[2]) begin
			st_d.uv_f = st_q.uv_sync[1];
		end

		st_d.status = fdio_pkg::FDIO_RST_ST;
		st_d.status[fdio_pkg::FDIO_ST_SHORT] = |short_f;
		st_d.status[fdio_pkg::FDIO_ST_OVL]   = |ovl_f;
		st_d.status[fdio_pkg::FDIO_ST_UV]    = st_q.uv_f;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q.mode    <= fdio_pkg::FDIO_RST_MODE;
			st_q.lvl_lo  <= fdio_pkg::FDIO_RST_LVL;
			st_q.lvl_hi  <= fdio_pkg::FDIO_RST_LVL;
			st_q.drive   <= fdio_pkg::FDIO_RST_OUT;
			st_q.in_proc <= fdio_pkg::FDIO_RST_OUT;
			st_q.status  <= fdio_pkg::FDIO_RST_ST;
			st_q.uv_sync <= fdio_pkg::FDIO_RST_SYNC;
			st_q.uv_f    <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign in_data     = st_q.in_proc;
	assign status_word = st_q.status;
	assign status_slot = fdio_pkg::FDIO_STATUS_SLOT;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	AST_PRM_MODE: assert property (
		prm_we && prm_idx == fdio_pkg::FDIO_PRM_BEHAV
		|=> st_q.mode == $past(prm_data[1:0]))
		else $error("behaviour byte not decoded from bits 0 and 1");

	AST_PRM_LEVELS: assert property (
		prm_we && prm_idx == fdio_pkg::FDIO_PRM_LVL_HI
		|=> sub_lvl[CH-1:8] == $past(prm_data))
		else $error("high substitute levels not stored");

	AST_SUB_LOW: assert property (
		!comm_ok && st_q.mode == fdio_pkg::FDIO_SUB_LOW
		|=> st_q.drive == '0)
		else $error("substitute low not applied");

	AST_SUB_HIGH: assert property (
		!comm_ok && st_q.mode == fdio_pkg::FDIO_SUB_HIGH
		|=> conn_pin4_out == '1 && conn_pin2_out == '1)
		else $error("substitute high not applied");

	AST_SUB_HOLD: assert property (
		!comm_ok && st_q.mode == fdio_pkg::FDIO_SUB_HOLD
		|=> $stable(st_q.drive))
		else $error("hold mode changed the outputs");

	AST_SUB_LVL: assert property (
		!comm_ok && st_q.mode == fdio_pkg::FDIO_SUB_LVL
		|=> st_q.drive == $past(sub_lvl))
		else $error("per-channel substitute levels not applied");

	AST_OUT_MAP: assert property (
		comm_ok && out_valid
		|=> conn_pin4_out[0] == $past(out_data[0])
		&& conn_pin2_out[0] == $past(out_data[1])
		&& conn_pin2_out[CH/2-1] == $past(out_data[CH-1]))
		else $error("output data not mapped to connector pins");

	AST_IN_MAP: assert property (
		($stable(conn_pin4_in) && $stable(conn_pin2_in)
		&& st_q.drive == '0)[*6]
		|-> in_data[0] == conn_pin4_in[0]
		&& in_data[1] == conn_pin2_in[0]
		&& in_data[CH-1] == conn_pin2_in[CH/2-1])
		else $error("input pins not mapped to input data");

	AST_ECHO: assert property (
		##1 (in_data & $past(st_q.drive)) == $past(st_q.drive))
		else $error("driven output not echoed in input data");

	AST_STATUS: assert property (
		##1 status_word[0] == $past(|short_f)
		&& status_word[1] == $past(|ovl_f)
		&& status_word[31:6] == '0 && status_word[4:2] == '0)
		else $error("status word layout wrong");

	AST_SLOT: assert property (
		status_slot == fdio_pkg::FDIO_STATUS_SLOT
		&& status_word[5] == $past(st_q.uv_f))
		else $error("status module slot or undervoltage wrong");

	// parameter port: only the three module bytes are kept
	AST_PRM_LVL_LO: assert property (
		prm_we && prm_idx == fdio_pkg::FDIO_PRM_LVL_LO
		|=> st_q.lvl_lo == $past(prm_data))
		else $error("low substitute levels not stored");

	AST_PRM_KEEP: assert property (
		!(prm_we && (prm_idx == fdio_pkg::FDIO_PRM_BEHAV
		|| prm_idx == fdio_pkg::FDIO_PRM_LVL_LO
		|| prm_idx == fdio_pkg::FDIO_PRM_LVL_HI))
		|=> $stable(st_q.mode) && $stable(st_q.lvl_lo)
		&& $stable(st_q.lvl_hi))
		else $error("module parameters changed without a write");

	AST_RSVD_KEEP: assert property (
		prm_we && prm_idx == fdio_pkg::FDIO_PRM_BEHAV
		&& prm_data[1:0] == st_q.mode
		|=> $stable(st_q.mode))
		else $error("reserved behaviour bits changed the mode");

	// output path while communication is good, and the substitute level pins
	AST_FOLLOW: assert property (
		comm_ok && out_valid |=> st_q.drive == $past(out_data))
		else $error("outputs did not follow the cyclic data");

	AST_HOLD_IDLE: assert property (
		comm_ok && !out_valid |=> $stable(st_q.drive))
		else $error("outputs moved without fresh cyclic data");

	AST_LVL_PINS: assert property (
		!comm_ok && st_q.mode == fdio_pkg::FDIO_SUB_LVL
		|=> conn_pin4_out[0] == $past(st_q.lvl_lo[0])
		&& conn_pin2_out[CH/4-1] == $past(st_q.lvl_lo[7])
		&& conn_pin4_out[CH/4] == $past(st_q.lvl_hi[0]))
		else $error("substitute level bits on wrong channels");

	// input side and status
	AST_DIR: assert property (
		##1 ((in_data ^ $past(pin_f)) & ~$past(st_q.drive)) == '0)
		else $error("undriven channel does not show its input");

	AST_LED_BYTE1: assert property (
		!st_q.drive[CH/2]
		|=> led_yellow[CH/2] == $past(pin_f[CH/2]))
		else $error("indicator ten not on channel nine");

	AST_UV_FILTER: assert property (
		$rose(st_q.uv_f) |-> $past(st_q.uv_sync[1])
		&& $past(st_q.uv_sync[2]))
		else $error("undervoltage accepted before stages agree");

	AST_SHORT_ANY: assert property (
		short_f[CH-1] |=> status_word[fdio_pkg::FDIO_ST_SHORT])
		else $error("short on channel sixteen not in status");

	AST_OVL_ANY: assert property (
		ovl_f[0] |=> status_word[fdio_pkg::FDIO_ST_OVL])
		else $error("overload on channel one not in status");

	AST_ECHO_TOP: assert property (
		st_q.drive[CH-1] |=> in_data[CH-1])
		else $error("channel sixteen output not echoed");

	COV_SUB_LVL: cover property (
		!comm_ok && st_q.mode == fdio_pkg::FDIO_SUB_LVL
		##1 st_q.drive != '0);
	COV_ECHO: cover property (comm_ok && out_valid && out_data != '0
		##2 in_data != '0);
	COV_RED: cover property (|led_red);
	COV_RESUME: cover property (!comm_ok ##1 comm_ok && out_valid);

endmodule
